// File: serial_host_model.sv
// host model that sends decoded serial commands
`timescale 1ns/1ps
module serial_host_model
    import servo_switch_pkg::*;
(
    input wire logic core_clk,
    output logic cmdValid,
    output command_t cmd
);
    initial cmdValid = 1'b0;
    initial cmd = '0;
    task automatic send(input command_t c);
        @(negedge core_clk);
        cmd = c;
        cmdValid = 1'b1;
        @(negedge core_clk);
        cmdValid = 1'b0;
        cmd = ~c; // released line never keeps old value
    endtask
endmodule // serial_host_model

// File: servo_memory_switch_control.sv
// memory-switch command interpreter, input masking and status output logic
`timescale 1ns/1ps
// Overview of operation
// - motion begin refused when target lies outside forward or reverse soft limits
// - jog motion stops at the applicable soft limit
// - act on commands carrying own axis identifier 01 to 98, and on unaddressed or id 99 commands as bit 8 selects
// - switch-A bit 0 homing direction, absolute sensor only with bit 1
// - switch-A bit 1 picks homing method 0/final offset or method 1
// - switch-A bit 2 selects incremental or absolute sensor
// - switch-A bit 3 enables x4 quadrature reference, one count per unit
// - reference pulses ignored during serial motion or jog, error counter untouched
// - absolute sensor per-revolution count checked against switch-A bits 7..4
// - switch-A bit 8 discards unaddressed commands, id 99 broadcasts
// - switch-A bit 9 addressed axis replies fault notice on receive error
// - switch-A bit 10 acknowledges every good command except warm reboot
// - switch-A bit 11 addressed axis echoes command text after reply
// - switch-A bits 13..12 select mode-switch detection source
// - switch-A bit 14 selects relative move origin during current limit
// - switch-B bits 0 and 3 mask drive-enable and fault-clear inputs
// - switch-B bit 1 masks both travel-limit inputs
// - switch-B bit 2 turns clamp inputs into jog, proportional input picks speed
// - switch-B bit 4 inverts slowdown input during homing
// - switch-B bits 7..6 = 01 enable special inputs, host masks overlaps
// - switch-B bits 8..11 hand status outputs to the status-force bits
// - special inputs take 4-bit function codes from the allocation words
module servo_memory_switch_control
    import servo_switch_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cmdValid,
    input wire command_t cmd,
    input wire logic signed [31:0] actualPos,
    input wire logic motionDone,
    input wire logic homeDone,
    input wire logic encStep,
    input wire logic [15:0] pulsesPerRev,
    input wire status_t statusRaw,
    input wire logic fwdTravelLimitPin,
    input wire logic revTravelLimitPin,
    input wire logic fwdCurrentClampPin,
    input wire logic revCurrentClampPin,
    input wire logic proportionalSelectPin,
    input wire logic driveEnablePin,
    input wire logic faultClearPin,
    input wire logic slowdownSwitchPin,
    input wire logic refPhaseAPin,
    input wire logic refPhaseBPin,
    input wire logic indexPin,
    output logic replyValid,
    output reply_t reply,
    output logic motionStart,
    output logic homeSeekStart,
    output logic faultClearReq,
    output logic driveEnable,
    output logic fwdAllowed,
    output logic revAllowed,
    output logic manualFwdMove,
    output logic manualRevMove,
    output logic altManualSpeedSelect,
    output logic slowdownEffective,
    output logic cycleCountFault,
    output logic signed [31:0] refCount,
    output logic [15:0] modeSwitchLevel,
    output config_t cfg,
    output status_t statusOut
);

    localparam int NPINS = 11;

    logic [NPINS-1:0] pinMeta;
    logic [NPINS-1:0] pinSync;
    logic [NPINS-1:0] next_pinMeta;
    logic [NPINS-1:0] next_pinSync;
    logic [15:0] shadowA, shadowB, shadowAllocA, shadowAllocB;
    logic [15:0] swA, swB, allocA, allocB;
    logic signed [31:0] fwdLimit, revLimit;
    logic [6:0] axisId;
    logic [3:0] forceBits;
    logic serialEnable, serialMoving, homing, prevA, prevB, prevIndex, prevClear, indexSeen;
    logic [15:0] revPulses;
    logic [15:0] next_shadowA, next_shadowB, next_shadowAllocA, next_shadowAllocB;
    logic [15:0] next_swA, next_swB, next_allocA, next_allocB, next_modeSwitchLevel;
    logic signed [31:0] next_fwdLimit, next_revLimit, next_refCount;
    logic [6:0] next_axisId;
    logic [3:0] next_forceBits;
    logic next_serialEnable, next_serialMoving, next_homing;
    logic next_prevA, next_prevB, next_prevIndex, next_prevClear, next_indexSeen;
    logic [15:0] next_revPulses;
    logic next_replyValid, next_motionStart, next_homeSeekStart, next_faultClearReq;
    logic next_driveEnable, next_fwdAllowed, next_revAllowed;
    logic next_manualFwdMove, next_manualRevMove, next_altManualSpeedSelect;
    logic next_slowdownEffective, next_cycleCountFault;
    reply_t next_reply;
    config_t next_cfg;
    status_t next_statusOut;

    logic fwdLimPin, revLimPin, fwdClampPin, revClampPin, propPin, enPin, clrPin, decPin;
    logic refA, refB, idx;
    logic forMe, designated, limitsOn, outOfRange, receiveError, accepted;
    logic jogActive, fwdRoom, revRoom, refChanged, refUp;
    logic signed [16:0] revDiff;
    logic [16:0] revDev;
    logic [3:0] revTol;

    assign {fwdLimPin, revLimPin, fwdClampPin, revClampPin, propPin, enPin, clrPin, decPin,
            refA, refB, idx} = pinSync;

    // two-stage synchroniser for every pin; stage one is only read by stage two
    always_comb
    begin
        next_pinMeta = {fwdTravelLimitPin, revTravelLimitPin, fwdCurrentClampPin,
                        revCurrentClampPin, proportionalSelectPin, driveEnablePin,
                        faultClearPin, slowdownSwitchPin, refPhaseAPin, refPhaseBPin, indexPin};
        next_pinSync = pinMeta;
    end

    always_comb
    begin
        next_shadowA = shadowA;
        next_shadowB = shadowB;
        next_shadowAllocA = shadowAllocA;
        next_shadowAllocB = shadowAllocB;
        next_swA = swA;
        next_swB = swB;
        next_allocA = allocA;
        next_allocB = allocB;
        next_modeSwitchLevel = modeSwitchLevel;
        next_fwdLimit = fwdLimit;
        next_revLimit = revLimit;
        next_axisId = axisId;
        next_forceBits = forceBits;
        next_serialEnable = serialEnable;
        next_serialMoving = serialMoving && !motionDone;
        next_homing = homing && !homeDone;
        next_prevA = refA;
        next_prevB = refB;
        next_prevIndex = idx;
        next_prevClear = clrPin;
        next_indexSeen = indexSeen;
        next_revPulses = encStep ? revPulses + 16'h0001 : revPulses;
        next_refCount = refCount;
        next_replyValid = 1'b0;
        next_reply = '{kind: REPLY_NONE, echo: 1'b0};
        next_motionStart = 1'b0;
        next_homeSeekStart = 1'b0;
        next_cycleCountFault = cycleCountFault;

        // addressing: own id, or broadcast id 99 / no id depending on bit 8
        if (cmd.hasAxis)
        begin
            forMe = (cmd.axisId == axisId) || (swA[SA_NEED_AXIS] && cmd.axisId == AXIS_BROADCAST);
        end
        else
        begin
            forMe = !swA[SA_NEED_AXIS];
        end
        designated = cmd.hasAxis && (cmd.axisId == axisId);
        // both limits zero means soft limits unused
        limitsOn = (fwdLimit != LIMIT_RESET) || (revLimit != LIMIT_RESET);
        outOfRange = limitsOn && ((cmd.target > fwdLimit) || (cmd.target < revLimit));
        receiveError = cmd.malformed || (cmd.kind == CMD_MOTION_BEGIN &&
                       (!driveEnable || outOfRange));
        accepted = cmdValid && forMe && !receiveError;

        if (cmdValid && forMe && receiveError && designated && swA[SA_FAULT_REPLY])
        begin
            next_replyValid = 1'b1;
            next_reply.kind = REPLY_FAULT;
            next_reply.echo = swA[SA_ECHO];
        end
        else if (accepted && cmd.kind != CMD_WARM_REBOOT && swA[SA_ACK_REPLY])
        begin
            next_replyValid = 1'b1;
            next_reply.kind = REPLY_ACK;
            next_reply.echo = swA[SA_ECHO] && designated;
        end

        if (accepted)
        begin
            case (cmd.kind)
                CMD_MOTION_BEGIN:
                begin
                    next_motionStart = 1'b1;
                    next_serialMoving = 1'b1;
                end
                CMD_HOME_SEEK:
                begin
                    next_homeSeekStart = 1'b1;
                    next_homing = 1'b1;
                end
                CMD_STATUS_FORCE: next_forceBits = cmd.paramData[3:0];
                CMD_DRIVE_DISABLE: next_serialEnable = 1'b0;
                CMD_DRIVE_ENABLE: next_serialEnable = 1'b1;
                CMD_FAULT_CLEAR: next_cycleCountFault = 1'b0;
                CMD_PARAM_WRITE:
                begin
                    // switch words are held in shadow until warm reboot
                    if (cmd.paramIndex == PIDX_SWITCH_A)
                        next_shadowA = cmd.paramData[15:0];
                    else if (cmd.paramIndex == PIDX_SWITCH_B)
                        next_shadowB = cmd.paramData[15:0];
                    else if (cmd.paramIndex == PIDX_ALLOC_A)
                        next_shadowAllocA = cmd.paramData[15:0];
                    else if (cmd.paramIndex == PIDX_ALLOC_B)
                        next_shadowAllocB = cmd.paramData[15:0];
                    else if (cmd.paramIndex == PIDX_FWD_LIMIT)
                        next_fwdLimit = cmd.paramData;
                    else if (cmd.paramIndex == PIDX_REV_LIMIT)
                        next_revLimit = cmd.paramData;
                    else if (cmd.paramIndex == PIDX_AXIS_ID)
                        next_axisId = cmd.paramData[6:0];
                    else if (cmd.paramIndex == PIDX_MODE_LEVEL)
                        next_modeSwitchLevel = cmd.paramData[15:0];
                end
                CMD_WARM_REBOOT:
                begin
                    next_swA = shadowA;
                    next_swB = shadowB;
                    next_allocA = shadowAllocA;
                    next_allocB = shadowAllocB;
                    next_serialMoving = 1'b0;
                    next_homing = 1'b0;
                    next_forceBits = 4'h0;
                    next_cycleCountFault = 1'b0;
                    next_indexSeen = 1'b0;
                    next_refCount = 32'sh0000_0000;
                end
                default: next_forceBits = forceBits;
            endcase
        end

        // drive enable and travel-limit masking
        next_driveEnable = swB[SB_EN_MASK] ? serialEnable : enPin;
        next_fwdAllowed = swB[SB_OT_MASK] || fwdLimPin;
        next_revAllowed = swB[SB_OT_MASK] || revLimPin;
        next_faultClearReq = (accepted && cmd.kind == CMD_FAULT_CLEAR) ||
                             (!swB[SB_CLR_MASK] && clrPin && !prevClear);
        if (!swB[SB_CLR_MASK] && clrPin && !prevClear)
            next_cycleCountFault = 1'b0;

        // jog from clamp inputs; stops at soft limit and at travel limit
        fwdRoom = !limitsOn || (actualPos < fwdLimit);
        revRoom = !limitsOn || (actualPos > revLimit);
        next_manualFwdMove = swB[SB_EXT_JOG] && fwdClampPin && fwdRoom && next_fwdAllowed;
        next_manualRevMove = swB[SB_EXT_JOG] && revClampPin && revRoom && next_revAllowed;
        next_altManualSpeedSelect = swB[SB_EXT_JOG] && propPin;
        jogActive = manualFwdMove || manualRevMove;
        next_slowdownEffective = (homing && swB[SB_DEC_INV]) ? !decPin : decPin;

        // x4 quadrature: an edge of one phase alone is one unit; edges of both phases in one cycle count nothing
        refChanged = (refA != prevA) ^ (refB != prevB);
        refUp = prevA ^ refB;
        if (swA[SA_PULSE_TRAIN] && refChanged && !serialMoving && !jogActive)
            next_refCount = refUp ? refCount + 32'sh0000_0001 : refCount - 32'sh0000_0001;

        // per-revolution count check between index pulses, absolute sensor only
        revTol = swA[SA_TOL_LSB +: 4];
        revDiff = $signed({1'b0, revPulses}) - $signed({1'b0, pulsesPerRev});
        revDev = revDiff[16] ? 17'(-revDiff) : 17'(revDiff);
        if (idx && !prevIndex)
        begin
            next_revPulses = 16'h0000;
            next_indexSeen = 1'b1;
            // first index only starts the count, nothing to compare yet
            if (indexSeen && swA[SA_ABS_SENSOR] && revTol != 4'h0 && revDev > {13'h0, revTol})
                next_cycleCountFault = 1'b1;
        end

        next_cfg.homeDirNeg = swA[SA_HOME_DIR] && (!swA[SA_ABS_SENSOR] || swA[SA_HOME_METHOD]);
        if (swA[SA_HOME_METHOD])
            next_cfg.homeAction = HOME_METHOD1;
        else if (swA[SA_ABS_SENSOR])
            next_cfg.homeAction = HOME_FINAL_OFFSET;
        else
            next_cfg.homeAction = HOME_METHOD0;
        next_cfg.absSensor = swA[SA_ABS_SENSOR];
        next_cfg.pulseTrainOn = swA[SA_PULSE_TRAIN];
        next_cfg.modeSource = swA[SA_MODE_LSB +: 2];
        next_cfg.relFromActual = swA[SA_REL_ACTUAL];
        next_cfg.specialInputsEn = swB[SB_SPECIAL_LSB +: 2] == SPECIAL_ON;
        // overlapping masks are the host's duty; codes pass through untouched
        next_cfg.allocCodes = next_cfg.specialInputsEn ? {allocB[3:0], allocA} : 20'h00000;

        next_statusOut.fault = (swB[SB_OUT_MASK_LSB] ? forceBits[0] : statusRaw.fault)
                               ^ swB[SB_OUT_INV_LSB];
        next_statusOut.brake = (swB[SB_OUT_MASK_LSB + 1] ? forceBits[1] : statusRaw.brake)
                               ^ swB[SB_OUT_INV_LSB + 1];
        next_statusOut.inPosition = (swB[SB_OUT_MASK_LSB + 2] ? forceBits[2]
                                     : statusRaw.inPosition) ^ swB[SB_OUT_INV_LSB + 2];
        next_statusOut.currentLimiting = (swB[SB_OUT_MASK_LSB + 3] ? forceBits[3]
                                     : statusRaw.currentLimiting) ^ swB[SB_OUT_INV_LSB + 3];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pinMeta <= '0;
            pinSync <= '0;
            shadowA <= SWITCH_A_RESET;
            shadowB <= SWITCH_B_RESET;
            shadowAllocA <= ALLOC_RESET;
            shadowAllocB <= ALLOC_RESET;
            swA <= SWITCH_A_RESET;
            swB <= SWITCH_B_RESET;
            allocA <= ALLOC_RESET;
            allocB <= ALLOC_RESET;
            modeSwitchLevel <= MODE_LEVEL_RESET;
            fwdLimit <= LIMIT_RESET;
            revLimit <= LIMIT_RESET;
            axisId <= AXIS_ID_RESET;
            forceBits <= 4'h0;
            serialEnable <= 1'b0;
            serialMoving <= 1'b0;
            homing <= 1'b0;
            prevA <= 1'b0;
            prevB <= 1'b0;
            prevIndex <= 1'b0;
            prevClear <= 1'b0;
            indexSeen <= 1'b0;
            revPulses <= 16'h0000;
            refCount <= 32'sh0000_0000;
            replyValid <= 1'b0;
            reply <= '{kind: REPLY_NONE, echo: 1'b0};
            motionStart <= 1'b0;
            homeSeekStart <= 1'b0;
            faultClearReq <= 1'b0;
            driveEnable <= 1'b0;
            fwdAllowed <= 1'b0;
            revAllowed <= 1'b0;
            manualFwdMove <= 1'b0;
            manualRevMove <= 1'b0;
            altManualSpeedSelect <= 1'b0;
            slowdownEffective <= 1'b0;
            cycleCountFault <= 1'b0;
            cfg <= '0;
            statusOut <= '0;
        end
        else if (ce)
        begin
            pinMeta <= next_pinMeta;
            pinSync <= next_pinSync;
            shadowA <= next_shadowA;
            shadowB <= next_shadowB;
            shadowAllocA <= next_shadowAllocA;
            shadowAllocB <= next_shadowAllocB;
            swA <= next_swA;
            swB <= next_swB;
            allocA <= next_allocA;
            allocB <= next_allocB;
            modeSwitchLevel <= next_modeSwitchLevel;
            fwdLimit <= next_fwdLimit;
            revLimit <= next_revLimit;
            axisId <= next_axisId;
            forceBits <= next_forceBits;
            serialEnable <= next_serialEnable;
            serialMoving <= next_serialMoving;
            homing <= next_homing;
            prevA <= next_prevA;
            prevB <= next_prevB;
            prevIndex <= next_prevIndex;
            prevClear <= next_prevClear;
            indexSeen <= next_indexSeen;
            revPulses <= next_revPulses;
            refCount <= next_refCount;
            replyValid <= next_replyValid;
            reply <= next_reply;
            motionStart <= next_motionStart;
            homeSeekStart <= next_homeSeekStart;
            faultClearReq <= next_faultClearReq;
            driveEnable <= next_driveEnable;
            fwdAllowed <= next_fwdAllowed;
            revAllowed <= next_revAllowed;
            manualFwdMove <= next_manualFwdMove;
            manualRevMove <= next_manualRevMove;
            altManualSpeedSelect <= next_altManualSpeedSelect;
            slowdownEffective <= next_slowdownEffective;
            cycleCountFault <= next_cycleCountFault;
            cfg <= next_cfg;
            statusOut <= next_statusOut;
        end
    end

endmodule // servo_memory_switch_control

// File: servo_switch_pkg.sv
// constants, command and status types for the memory-switch control block
package servo_switch_pkg;

    localparam logic [5:0] PIDX_MODE_LEVEL = 6'd7;
    localparam logic [5:0] PIDX_FWD_LIMIT = 6'd30;
    localparam logic [5:0] PIDX_REV_LIMIT = 6'd31;
    localparam logic [5:0] PIDX_AXIS_ID = 6'd35;
    localparam logic [5:0] PIDX_SWITCH_A = 6'd36;
    localparam logic [5:0] PIDX_SWITCH_B = 6'd37;
    localparam logic [5:0] PIDX_ALLOC_A = 6'd38;
    localparam logic [5:0] PIDX_ALLOC_B = 6'd39;

    localparam logic [15:0] SWITCH_A_RESET = 16'h0000;
    localparam logic [15:0] SWITCH_B_RESET = 16'h0000;
    localparam logic [15:0] ALLOC_RESET = 16'h0000;
    localparam logic [15:0] MODE_LEVEL_RESET = 16'h0000;
    localparam logic signed [31:0] LIMIT_RESET = 32'sh0000_0000;
    localparam logic [6:0] AXIS_ID_RESET = 7'h01;
    localparam logic [6:0] AXIS_BROADCAST = 7'h63;

    localparam int SA_HOME_DIR = 0;
    localparam int SA_HOME_METHOD = 1;
    localparam int SA_ABS_SENSOR = 2;
    localparam int SA_PULSE_TRAIN = 3;
    localparam int SA_TOL_LSB = 4;
    localparam int SA_NEED_AXIS = 8;
    localparam int SA_FAULT_REPLY = 9;
    localparam int SA_ACK_REPLY = 10;
    localparam int SA_ECHO = 11;
    localparam int SA_MODE_LSB = 12;
    localparam int SA_REL_ACTUAL = 14;
    localparam int SB_EN_MASK = 0;
    localparam int SB_OT_MASK = 1;
    localparam int SB_EXT_JOG = 2;
    localparam int SB_CLR_MASK = 3;
    localparam int SB_DEC_INV = 4;
    localparam int SB_SPECIAL_LSB = 6;
    localparam int SB_OUT_MASK_LSB = 8;
    localparam int SB_OUT_INV_LSB = 12;
    localparam logic [1:0] SPECIAL_ON = 2'h1;

    typedef enum logic [3:0] {
        CMD_OTHER = 4'h0,
        CMD_MOTION_BEGIN = 4'h1,
        CMD_HOME_SEEK = 4'h2,
        CMD_WARM_REBOOT = 4'h3,
        CMD_STATUS_FORCE = 4'h4,
        CMD_PARAM_WRITE = 4'h5,
        CMD_DRIVE_DISABLE = 4'h6,
        CMD_DRIVE_ENABLE = 4'h7,
        CMD_FAULT_CLEAR = 4'h8
    } cmd_kind_t;

    typedef enum logic [1:0] {
        HOME_METHOD0 = 2'h0,
        HOME_FINAL_OFFSET = 2'h1,
        HOME_METHOD1 = 2'h2
    } home_action_t;

    typedef enum logic [1:0] {
        REPLY_NONE = 2'h0,
        REPLY_ACK = 2'h1,
        REPLY_FAULT = 2'h2
    } reply_kind_t;

    typedef struct packed {
        cmd_kind_t kind;
        logic hasAxis;
        logic [6:0] axisId;
        logic malformed;
        logic signed [31:0] target;
        logic [5:0] paramIndex;
        logic [31:0] paramData;
    } command_t;

    typedef struct packed {
        reply_kind_t kind;
        logic echo;
    } reply_t;

    typedef struct packed {
        logic homeDirNeg;
        home_action_t homeAction;
        logic absSensor;
        logic pulseTrainOn;
        logic [1:0] modeSource;
        logic relFromActual;
        logic specialInputsEn;
        logic [19:0] allocCodes;
    } config_t;

    typedef struct packed {
        logic fault;
        logic brake;
        logic inPosition;
        logic currentLimiting;
    } status_t;

endpackage

// File: servo_switch_sva.sv
// assertion checker for the memory-switch control block
`timescale 1ns/1ps
module servo_switch_sva
    import servo_switch_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cmdValid,
    input wire command_t cmd,
    input wire logic replyValid,
    input wire reply_t reply,
    input wire logic motionStart,
    input wire logic homeSeekStart,
    input wire logic cycleCountFault,
    input wire logic signed [31:0] refCount,
    input wire config_t cfg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire taken = cmdValid && ce;
    wire mbCmd = taken && cmd.kind == CMD_MOTION_BEGIN;
    wire homeCmd = taken && cmd.kind == CMD_HOME_SEEK;
    wire rebootCmd = taken && cmd.kind == CMD_WARM_REBOOT;
    sequence reboot_s;
        rebootCmd;
    endsequence
    AST_START: assert property (motionStart |-> $past(mbCmd))
        else $error("motion start without command");
    AST_HOME: assert property (homeSeekStart |-> $past(homeCmd))
        else $error("home seek without command");
    AST_REPLY_CAUSE: assert property (replyValid |-> $past(taken))
        else $error("reply without command");
    AST_FAULT_OWN: assert property (replyValid && reply.kind == REPLY_FAULT |-> $past(cmd.hasAxis))
        else $error("fault reply to unaddressed command");
    AST_ECHO_OWN: assert property (replyValid && reply.echo |-> $past(cmd.hasAxis))
        else $error("echo to unaddressed command");
    AST_REBOOT_QUIET: assert property (reboot_s |=> !(replyValid && reply.kind == REPLY_ACK))
        else $error("ack after warm reboot");
    AST_CFG_HOLD: assert property (!$stable(cfg) |-> $past(rebootCmd, 2))
        else $error("config changed without reboot");
    AST_FINAL_OFS: assert property (cfg.homeAction == HOME_FINAL_OFFSET |-> cfg.absSensor)
        else $error("final offset homing with incremental sensor");
    AST_NO_COUNT: assert property (!cfg.pulseTrainOn |-> $stable(refCount))
        else $error("reference counted with pulse train off");
    AST_NO_FAULT: assert property (!cfg.absSensor |-> !$rose(cycleCountFault))
        else $error("cycle fault with incremental sensor");
endmodule // servo_switch_sva
bind servo_memory_switch_control servo_switch_sva chk (.core_clk, .rst_n, .ce, .cmdValid, .cmd,
    .replyValid, .reply, .motionStart, .homeSeekStart, .cycleCountFault, .refCount, .cfg);

// File: tb_top.sv
// self-checking bench for the memory-switch control block
`timescale 1ns/1ps
module tb_top
    import servo_switch_pkg::*;
;
    logic core_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, encStep = 1'b0, indexPin = 1'b0;
    logic fwdTravelLimitPin = 1'b1, revTravelLimitPin = 1'b1, driveEnablePin = 1'b0;
    logic fwdCurrentClampPin = 1'b0, revCurrentClampPin = 1'b0, proportionalSelectPin = 1'b0;
    logic faultClearPin = 1'b0, slowdownSwitchPin = 1'b0, refPhaseAPin = 1'b0, refPhaseBPin = 1'b0;
    logic motionDone = 1'b0, homeDone = 1'b0, cmdValid, replyValid, motionStart, homeSeekStart;
    logic faultClearReq, driveEnable, fwdAllowed, revAllowed, manualFwdMove, manualRevMove;
    logic altManualSpeedSelect, slowdownEffective, cycleCountFault;
    logic [15:0] pulsesPerRev = 16'h0400, modeSwitchLevel, swA = 16'h0, swB = 16'h0, shA, shB;
    logic signed [31:0] actualPos = 32'sh0, refCount;
    status_t statusRaw = 4'h0, statusOut;
    command_t cmd;
    reply_t reply;
    config_t cfg;
    logic [31:0] seed = 32'hED93, r, q;
    int err_count = 0, checks_done = 0, myId = 1, lo = 0, hi = 0, en = 0;
    int axs [4] = '{-1, 5, 99, 7};
    logic [15:0] pa [2] = '{16'h5F07, 16'h241D}, pb [2] = '{16'h0F03, 16'h0000};
    cmd_kind_t kinds [8] = '{CMD_MOTION_BEGIN, CMD_MOTION_BEGIN, CMD_OTHER, CMD_DRIVE_ENABLE,
        CMD_DRIVE_DISABLE, CMD_HOME_SEEK, CMD_FAULT_CLEAR, CMD_OTHER};
    servo_memory_switch_control dut (.*);
    serial_host_model host (.core_clk, .cmdValid, .cmd);
    initial forever #50 core_clk = ~core_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // unchecked pins wander so the logic behind them moves
    always @(negedge core_clk)
    begin
        q = rnd();
        {refPhaseAPin, refPhaseBPin, fwdCurrentClampPin, revCurrentClampPin, encStep} <= q[4:0];
        {proportionalSelectPin, slowdownSwitchPin, revTravelLimitPin, motionDone} <= q[8:5];
        {homeDone, indexPin} <= q[10:9];
        actualPos <= {{20{q[31]}}, q[31:20]};
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    function automatic config_t ecfg(input logic [15:0] a, input logic [15:0] b);
        ecfg = '0;
        ecfg.homeDirNeg = a[0] && (!a[2] || a[1]);
        ecfg.homeAction = a[1] ? HOME_METHOD1 : a[2] ? HOME_FINAL_OFFSET : HOME_METHOD0;
        {ecfg.absSensor, ecfg.pulseTrainOn} = {a[2], a[3]};
        {ecfg.modeSource, ecfg.relFromActual} = {a[13:12], a[14]};
        ecfg.specialInputsEn = b[7:6] == 2'h1;
    endfunction
    task automatic cmdx(input cmd_kind_t k, input int ax, mal, tgt, idx, dat);
        command_t c;
        logic own, ok, err;
        logic [1:0] rk;
        logic [2:0] ex;
        c = '0;
        {c.kind, c.hasAxis, c.axisId, c.malformed} = {k, ax >= 0, 7'(ax), mal != 0};
        {c.target, c.paramIndex, c.paramData} = {tgt, 6'(idx), dat};
        own = ax == myId;
        ok = own || (ax < 0 && !swA[8]) || (ax == 99 && swA[8]);
        err = mal != 0 || (k == CMD_MOTION_BEGIN && ((swB[0] && en == 0)
            || ((lo != 0 || hi != 0) && (tgt < lo || tgt > hi))));
        rk = !ok ? 2'h0 : err ? {swA[9] && own, 1'b0} : {1'b0, swA[10] && k != CMD_WARM_REBOOT};
        ok = ok && !err;
        ex = {ok && k == CMD_MOTION_BEGIN, ok && k == CMD_HOME_SEEK, ok && k == CMD_FAULT_CLEAR};
        host.send(c);
        chk("pulses", ex, {motionStart, homeSeekStart, faultClearReq});
        chk("replyValid", rk != 2'h0, replyValid);
        if (rk != 2'h0)
            chk("reply", {rk, swA[11] && own}, reply);
        if (ok && (k == CMD_DRIVE_ENABLE || k == CMD_DRIVE_DISABLE))
            en = k == CMD_DRIVE_ENABLE;
        if (ok && k == CMD_WARM_REBOOT)
            {swA, swB} = {shA, shB};
        if (ok && k == CMD_PARAM_WRITE)
            case (idx)
                30: hi = dat;
                31: lo = dat;
                35: myId = dat;
                36: shA = dat[15:0];
                37: shB = dat[15:0];
                default: ;
            endcase
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        give_verdict();
    end
    initial
    begin
        repeat (16) @(negedge core_clk);
        {rst_n, fwdTravelLimitPin, driveEnablePin, statusRaw} = {3'h5, 4'hA};
        cmdx(CMD_PARAM_WRITE, 1, 0, 0, 35, 5);
        cmdx(CMD_PARAM_WRITE, 5, 0, 0, 30, 1000);
        cmdx(CMD_PARAM_WRITE, 5, 0, 0, 31, -1000);
        cmdx(CMD_PARAM_WRITE, 5, 0, 0, 7, 16'h1234);
        chk("modeLevel", 16'h1234, modeSwitchLevel);
        for (int p = 0; p < 2; p++)
        begin
            cmdx(CMD_PARAM_WRITE, myId, 0, 0, 36, pa[p]);
            cmdx(CMD_PARAM_WRITE, myId, 0, 0, 37, pb[p]);
            chk("cfgHeld", ecfg(swA, swB), cfg);
            cmdx(CMD_WARM_REBOOT, myId, 0, 0, 0, 0);
            repeat (2) @(posedge core_clk);
            #1;
            chk("cfg", ecfg(swA, swB), cfg);
            chk("fwdAllowed", swB[1], fwdAllowed);
            chk("driveEnable", swB[0] ? en : 1, driveEnable);
            cmdx(CMD_STATUS_FORCE, myId, 0, 0, 0, 4'hA);
            repeat (2) @(posedge core_clk);
            #1;
            chk("statusOut", swB[11:8] == 4'hF ? 4'h5 : 4'hA, statusOut);
            cmdx(CMD_DRIVE_ENABLE, myId, 0, 0, 0, 0);
            cmdx(CMD_MOTION_BEGIN, myId, 0, 1000, 0, 0);
            cmdx(CMD_MOTION_BEGIN, myId, 0, -1001, 0, 0);
            for (int i = 0; i < 40; i++)
            begin
                r = rnd();
                cmdx(kinds[r[2:0]], axs[r[5:4]], r[8:6] == 3'h0, 10 * int'(r[15:8]) - 1280, 0, 0);
            end
        end
        give_verdict();
    end
endmodule // tb_top
